// ---- src/ccf_filter.v ----
// cycle-count filter register with access traps and count gating
// How it works
// [R1] counter counts only in permitted levels/states
// [R2] filter register is 32 bits wide
// [R3] absent feature makes every access undefined
// [R4] bit 31 excludes EL1 cycles
// [R5] bit 30 excludes EL0 cycles
// [R6] nonsecure EL1 counts when bit 29 matches 31
// [R7] nonsecure EL0 counts when bit 28 matches 30
// [R8] bit 27 set enables EL2 counting
// [R9] missing EL2/EL3 makes fields read zero
// [R10] realm EL0 counts when bit 21 matches 30
// [R11] warm reset clears bits 31 to 27
// [R12] realm bit left unreset after warm reset
// [R13] also reachable via selected event type
// [R14] core uses fixed coprocessor encoding
// [R15] EL0 without user enable traps or undefined
// [R16] fine-grained read trap sends EL0 to EL2
// [R17] hyp pmu trap sends EL0/EL1 to EL2
// [R18] 32-bit hyp pmu trap raises hyp trap
// [R19] monitor pmu trap to EL3, halted debug undefined
// [R20] reserved bits read zero, ignore writes
`timescale 1ns/10ps
`include "ccf_defines.vh"

module ccf_filter #(
  parameter HAVE_A32 = 1,
  parameter HAVE_PMU = 1,
  parameter HAVE_EL2 = 1,
  parameter HAVE_EL3 = 1,
  parameter HAVE_REALM = 1,
  parameter EL3_DEBUG_PRIO = 0,
  parameter [3:0] SEL_CRN = 4'h9,
  parameter [3:0] SEL_CRM = 4'hd,
  parameter [2:0] SEL_OPC2 = 3'h1
) (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // coprocessor access request
  input wire acc_valid_i,
  input wire acc_write_i,
  input wire [3:0] acc_coproc_i,
  input wire [2:0] acc_opc1_i,
  input wire [3:0] acc_crn_i,
  input wire [3:0] acc_crm_i,
  input wire [2:0] acc_opc2_i,
  input wire [31:0] acc_wdata_i,
  // external debug and 64-bit state write path
  input wire ext_write_i,
  input wire [31:0] ext_wdata_i,
  // core state
  input wire [1:0] cur_el_i,
  input wire [1:0] cur_sec_i,
  input wire el1_a32_i,
  input wire el2_a32_i,
  input wire el3_a32_i,
  input wire el2_enabled_i,
  input wire halted_i,
  // trap controls
  input wire user_access_enable_i,
  input wire trap_general_exceptions_i,
  input wire host_el2_i,
  input wire fgt_allowed_i,
  input wire fine_grain_read_trap_i,
  input wire fine_grain_write_trap_i,
  input wire hyp_pmu_trap_i,
  input wire hyp_pmu_trap_a32_i,
  input wire monitor_pmu_trap_i,
  input wire secure_debug_disable_i,
  input wire [4:0] counter_select_i,
  // access answer
  output reg acc_done_o,
  output reg [31:0] acc_rdata_o,
  output reg acc_undef_o,
  output reg acc_trap_o,
  output reg acc_hyp_trap_o,
  output reg [1:0] acc_trap_el_o,
  output reg [5:0] acc_syndrome_o,
  // filter state
  output wire [31:0] cycle_count_filter_o,
  output wire cycle_count_permit_o
);

  localparam RES_OK = 4'b0001;
  localparam RES_UNDEF = 4'b0010;
  localparam RES_TRAP = 4'b0100;
  localparam RES_HYP = 4'b1000;

  localparam [0:0] P_EL2 = (HAVE_EL2 != 0);
  localparam [0:0] P_EL3 = (HAVE_EL3 != 0);
  localparam [0:0] P_REALM = (HAVE_REALM != 0);
  localparam [0:0] P_PRESENT = (HAVE_A32 != 0) && (HAVE_PMU != 0);
  localparam [0:0] P_DEBUG_PRIO = (EL3_DEBUG_PRIO != 0);

  // ========================================================================
  // field storage
  reg kernel_exclude_reg;
  reg lowest_level_mask_reg;
  reg nonsecure_kernel_flt_reg;
  reg nonsecure_app_flt_reg;
  reg hyp_level_count_reg;
  reg realm_app_flt_reg;

  // ========================================================================
  // access decode
  wire direct_hit;
  wire select_hit;
  wire acc_hit;
  reg [3:0] res_next;
  reg [1:0] trap_el_next;
  reg [5:0] syn_next;
  reg debug_undef_early;
  reg el3_trap;
  reg fg_trap;
  wire acc_write_ok;
  wire write_any;
  wire [31:0] write_data;
  wire [31:0] cycle_count_filter_reg;

  assign direct_hit = (acc_coproc_i == `CCF_COPROC) &&
                      (acc_opc1_i == `CCF_OPC1) &&
                      (acc_crn_i == `CCF_CRN) &&
                      (acc_crm_i == `CCF_CRM) &&
                      (acc_opc2_i == `CCF_OPC2); // [R14]
  assign select_hit = (acc_coproc_i == `CCF_COPROC) &&
                      (acc_opc1_i == `CCF_OPC1) &&
                      (acc_crn_i == SEL_CRN) &&
                      (acc_crm_i == SEL_CRM) &&
                      (acc_opc2_i == SEL_OPC2) &&
                      (counter_select_i == `CCF_SEL_CYCLE); // [R13]
  assign acc_hit = acc_valid_i && (direct_hit || select_hit);

  // ========================================================================
  // trap priority
  always @* begin
    res_next = RES_OK;
    trap_el_next = `CCF_EL1;
    syn_next = `CCF_SYN_PMU;
    debug_undef_early = halted_i && P_EL3 && secure_debug_disable_i &&
                        P_DEBUG_PRIO && !el3_a32_i && monitor_pmu_trap_i;
    el3_trap = P_EL3 && !el3_a32_i && monitor_pmu_trap_i;
    fg_trap = acc_write_i ? fine_grain_write_trap_i :
                            fine_grain_read_trap_i;
    if (!P_PRESENT) begin
      res_next = RES_UNDEF; // [R3]
    end else if (cur_el_i == `CCF_EL0) begin
      if (debug_undef_early) begin
        res_next = RES_UNDEF; // [R19]
      end else if (!el1_a32_i && !user_access_enable_i) begin
        res_next = RES_TRAP; // [R15]
        if (el2_enabled_i && !el2_a32_i && trap_general_exceptions_i) begin
          trap_el_next = `CCF_EL2;
        end
      end else if (el1_a32_i && !user_access_enable_i) begin
        if (el2_enabled_i && !el2_a32_i && trap_general_exceptions_i) begin
          res_next = RES_TRAP; // [R15]
          trap_el_next = `CCF_EL2;
        end else if (el2_enabled_i && el2_a32_i &&
                     trap_general_exceptions_i) begin
          res_next = RES_HYP;
          trap_el_next = `CCF_EL2;
          syn_next = `CCF_SYN_UNKNOWN;
        end else begin
          res_next = RES_UNDEF; // [R15]
        end
      end else if (el2_enabled_i && !el1_a32_i &&
                   !(host_el2_i && trap_general_exceptions_i) &&
                   (!P_EL3 || fgt_allowed_i) && fg_trap) begin
        res_next = RES_TRAP; // [R16]
        trap_el_next = `CCF_EL2;
      end else if (el2_enabled_i && !el2_a32_i && hyp_pmu_trap_i) begin
        res_next = RES_TRAP; // [R17]
        trap_el_next = `CCF_EL2;
      end else if (el2_enabled_i && el2_a32_i && hyp_pmu_trap_a32_i) begin
        res_next = RES_HYP; // [R18]
        trap_el_next = `CCF_EL2;
      end else if (el3_trap) begin
        if (halted_i && secure_debug_disable_i) begin
          res_next = RES_UNDEF; // [R19]
        end else begin
          res_next = RES_TRAP; // [R19]
          trap_el_next = `CCF_EL3;
        end
      end
    end else if (cur_el_i == `CCF_EL1) begin
      if (debug_undef_early) begin
        res_next = RES_UNDEF; // [R19]
      end else if (el2_enabled_i && !el2_a32_i && hyp_pmu_trap_i) begin
        res_next = RES_TRAP; // [R17]
        trap_el_next = `CCF_EL2;
      end else if (el2_enabled_i && el2_a32_i && hyp_pmu_trap_a32_i) begin
        res_next = RES_HYP; // [R18]
        trap_el_next = `CCF_EL2;
      end else if (el3_trap) begin
        if (halted_i && secure_debug_disable_i) begin
          res_next = RES_UNDEF; // [R19]
        end else begin
          res_next = RES_TRAP; // [R19]
          trap_el_next = `CCF_EL3;
        end
      end
    end else if (cur_el_i == `CCF_EL2) begin
      if (debug_undef_early) begin
        res_next = RES_UNDEF; // [R19]
      end else if (el3_trap) begin
        if (halted_i && secure_debug_disable_i) begin
          res_next = RES_UNDEF; // [R19]
        end else begin
          res_next = RES_TRAP; // [R19]
          trap_el_next = `CCF_EL3;
        end
      end
    end
  end

  // ========================================================================
  // write path
  assign acc_write_ok = acc_hit && acc_write_i && (res_next == RES_OK);
  assign write_any = acc_write_ok || (ext_write_i && P_PRESENT);
  assign write_data = acc_write_ok ? acc_wdata_i : ext_wdata_i;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      kernel_exclude_reg <= `CCF_FIELD_RESET; // [R11]
      lowest_level_mask_reg <= `CCF_FIELD_RESET; // [R11]
      nonsecure_kernel_flt_reg <= `CCF_FIELD_RESET; // [R11]
      nonsecure_app_flt_reg <= `CCF_FIELD_RESET; // [R11]
      hyp_level_count_reg <= `CCF_FIELD_RESET; // [R11]
    end else if (write_any) begin
      kernel_exclude_reg <= write_data[`CCF_KERNEL_EXCLUDE_BIT]; // [R4]
      lowest_level_mask_reg <= write_data[`CCF_LOWEST_LEVEL_MASK_BIT]; // [R5]
      nonsecure_kernel_flt_reg <=
        write_data[`CCF_NONSECURE_KERNEL_BIT] & P_EL3; // [R9]
      nonsecure_app_flt_reg <=
        write_data[`CCF_NONSECURE_APP_BIT] & P_EL3; // [R9]
      hyp_level_count_reg <=
        write_data[`CCF_HYP_LEVEL_COUNT_BIT] & P_EL2; // [R9]
    end
  end

  // realm bit keeps no reset value
  always @(posedge clk_i) begin
    if (write_any) begin
      realm_app_flt_reg <= write_data[`CCF_REALM_APP_BIT]; // [R12]
    end
  end

  // ========================================================================
  // read view, shared by all views
  assign cycle_count_filter_reg = {
    kernel_exclude_reg,
    lowest_level_mask_reg,
    nonsecure_kernel_flt_reg & P_EL3,
    nonsecure_app_flt_reg & P_EL3,
    hyp_level_count_reg & P_EL2,
    5'h00,
    realm_app_flt_reg & P_REALM,
    21'h00_0000
  }; // [R2] [R20] [R9]
  assign cycle_count_filter_o = cycle_count_filter_reg;

  // ========================================================================
  // access answer
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_done_o <= 1'b0;
      acc_rdata_o <= `CCF_REG_RESET;
      acc_undef_o <= 1'b0;
      acc_trap_o <= 1'b0;
      acc_hyp_trap_o <= 1'b0;
      acc_trap_el_o <= `CCF_EL0;
      acc_syndrome_o <= `CCF_SYN_UNKNOWN;
    end else begin
      acc_done_o <= acc_hit;
      acc_undef_o <= acc_hit && (res_next == RES_UNDEF);
      acc_trap_o <= acc_hit && (res_next == RES_TRAP);
      acc_hyp_trap_o <= acc_hit && (res_next == RES_HYP);
      if (acc_hit && (res_next != RES_OK) && (res_next != RES_UNDEF)) begin
        acc_trap_el_o <= trap_el_next;
        acc_syndrome_o <= syn_next;
      end else begin
        acc_trap_el_o <= `CCF_EL0;
        acc_syndrome_o <= `CCF_SYN_UNKNOWN;
      end
      if (acc_hit && !acc_write_i && (res_next == RES_OK)) begin
        acc_rdata_o <= cycle_count_filter_reg;
      end else begin
        acc_rdata_o <= `CCF_REG_RESET;
      end
    end
  end

  // ========================================================================
  // count permission
  reg permit;
  always @* begin
    permit = 1'b0;
    case (cur_el_i)
      `CCF_EL0: begin
        if (cur_sec_i == `CCF_SEC_NONSECURE && P_EL3) begin
          permit = (nonsecure_app_flt_reg == lowest_level_mask_reg); // [R7]
        end else if (cur_sec_i == `CCF_SEC_REALM && P_REALM) begin
          permit = (realm_app_flt_reg == lowest_level_mask_reg); // [R10]
        end else begin
          permit = !lowest_level_mask_reg; // [R5]
        end
      end
      `CCF_EL1: begin
        if (cur_sec_i == `CCF_SEC_NONSECURE && P_EL3) begin
          permit = (nonsecure_kernel_flt_reg == kernel_exclude_reg); // [R6]
        end else begin
          permit = !kernel_exclude_reg; // [R4]
        end
      end
      `CCF_EL2: begin
        permit = hyp_level_count_reg & P_EL2; // [R8]
      end
      default: begin
        permit = !kernel_exclude_reg;
      end
    endcase
  end
  assign cycle_count_permit_o = permit & P_PRESENT; // [R1]

endmodule // ccf_filter

// ---- common/ccf_defines.vh ----
// constants for the cycle-count filter register block
`ifndef CCF_DEFINES_VH
`define CCF_DEFINES_VH

// ==========================================================================
// field positions
`define CCF_KERNEL_EXCLUDE_BIT 31
`define CCF_LOWEST_LEVEL_MASK_BIT 30
`define CCF_NONSECURE_KERNEL_BIT 29
`define CCF_NONSECURE_APP_BIT 28
`define CCF_HYP_LEVEL_COUNT_BIT 27
`define CCF_REALM_APP_BIT 21

// ==========================================================================
// reset values
`define CCF_FIELD_RESET 1'b0
`define CCF_REG_RESET 32'h0000_0000

// ==========================================================================
// direct access encoding
`define CCF_COPROC 4'hf
`define CCF_OPC1 3'h0
`define CCF_CRN 4'he
`define CCF_CRM 4'hf
`define CCF_OPC2 3'h7

// ==========================================================================
// selected event type access
`define CCF_SEL_CYCLE 5'h1f

// ==========================================================================
// syndrome codes
`define CCF_SYN_PMU 6'h03
`define CCF_SYN_UNKNOWN 6'h00

// ==========================================================================
// exception levels
`define CCF_EL0 2'h0
`define CCF_EL1 2'h1
`define CCF_EL2 2'h2
`define CCF_EL3 2'h3

// ==========================================================================
// security states
`define CCF_SEC_SECURE 2'h0
`define CCF_SEC_NONSECURE 2'h1
`define CCF_SEC_REALM 2'h2

`endif

// ---- tb/ccf_filter_properties.sv ----
// port assertions for the cycle-count filter register
`timescale 1ns/10ps
module ccf_filter_properties (
  // clock, reset, request
  input wire clk_i,
  input wire resetn_i,
  input wire acc_valid_i,
  // core state
  input wire [1:0] cur_el_i,
  input wire el2_a32_i,
  input wire el2_enabled_i,
  input wire hyp_pmu_trap_i,
  // answer and filter state
  input wire acc_done_o,
  input wire acc_undef_o,
  input wire acc_trap_o,
  input wire acc_hyp_trap_o,
  input wire [1:0] acc_trap_el_o,
  input wire [5:0] acc_syndrome_o,
  input wire [31:0] cycle_count_filter_o,
  input wire cycle_count_permit_o
);
  // ==========================================
  // helpers
  wire [31:0] f = cycle_count_filter_o;
  wire pm = cycle_count_permit_o;
  wire hyp_req = acc_valid_i & el2_enabled_i & ~el2_a32_i & hyp_pmu_trap_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================
  // properties
  property p_done; acc_done_o |-> $past(acc_valid_i); endproperty
  a_done: assert property (p_done) else $error("lone answer");
  property p_syn; acc_trap_o |-> acc_syndrome_o == 6'h03; endproperty
  a_syn: assert property (p_syn) else $error("bad syndrome");
  property p_resv; f[26:22] == 5'h00 && f[20:0] == 21'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_rst; $rose(resetn_i) |-> f[31:27] == 5'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_el2; cur_el_i == 2'h2 |-> pm == f[27]; endproperty
  a_el2: assert property (p_el2) else $error("el2 permit");
  property p_one;
    acc_done_o |-> $onehot0({acc_undef_o, acc_trap_o, acc_hyp_trap_o});
  endproperty
  a_one: assert property (p_one) else $error("two outcomes");
  property p_undef;
    acc_undef_o |-> acc_done_o && acc_syndrome_o == 6'h00;
  endproperty
  a_undef: assert property (p_undef) else $error("undef form");
  property p_hyp;
    hyp_req && cur_el_i == 2'h1 |=>
      !acc_done_o || (acc_trap_o && acc_trap_el_o == 2'h2);
  endproperty
  a_hyp: assert property (p_hyp) else $error("el1 trap");
  c_trap: cover property (acc_trap_o);
  c_undef: cover property (acc_undef_o);
  c_hyp: cover property (acc_hyp_trap_o);
endmodule // ccf_filter_properties

bind ccf_filter ccf_filter_properties props (.clk_i(clk_i),
  .resetn_i(resetn_i), .acc_valid_i(acc_valid_i), .cur_el_i(cur_el_i),
  .el2_a32_i(el2_a32_i), .el2_enabled_i(el2_enabled_i),
  .hyp_pmu_trap_i(hyp_pmu_trap_i), .acc_done_o(acc_done_o),
  .acc_undef_o(acc_undef_o), .acc_trap_o(acc_trap_o),
  .acc_hyp_trap_o(acc_hyp_trap_o), .acc_trap_el_o(acc_trap_el_o),
  .acc_syndrome_o(acc_syndrome_o),
  .cycle_count_filter_o(cycle_count_filter_o),
  .cycle_count_permit_o(cycle_count_permit_o));

// ---- tb/ccf_core_model.sv ----
// core model issuing coprocessor register accesses
`timescale 1ns/10ps
module ccf_core_model (
  // clock
  input wire clk_i,
  // access request
  output reg valid_o,
  output reg write_o,
  output reg [17:0] enc_o,
  output reg [31:0] wdata_o
);
  // ==========================================
  // idle
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    enc_o = 18'h0_0000;
    wdata_o = 32'h0;
  end
  // ==========================================
  // one access, held until the taking edge
  task access(input wr, input sel, input [31:0] d);
    begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      write_o <= wr;
      enc_o <= sel ? {4'hf, 3'h0, 4'h9, 4'hd, 3'h1}
        : {4'hf, 3'h0, 4'he, 4'hf, 3'h7};
      wdata_o <= d;
      @(posedge clk_i);
      valid_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask
endmodule // ccf_core_model

// ---- tb/cycle_count_filter_test.sv ----
// self-checking bench for the cycle-count filter register
`timescale 1ns/10ps
module cycle_count_filter_test;
  // ==========================================
  // signals
  reg clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg ext_w = 1'b0;
  reg [31:0] ext_d = 32'h0;
  reg [1:0] el = 2'h3;
  reg [1:0] sec = 2'h1;
  reg [4:0] cs = 5'h1f;
  reg [14:0] c = 15'h0000;
  wire v, w, done, ud, tr, hy, pm;
  wire [17:0] e;
  wire [1:0] tel;
  wire [5:0] syn;
  wire [31:0] wd, rd, flt;
  integer failures = 0;
  integer check_count = 0;
  always #10 clk_i = ~clk_i;
  ccf_core_model core (.clk_i(clk_i), .valid_o(v), .write_o(w),
    .enc_o(e), .wdata_o(wd));
  ccf_filter uut (.clk_i(clk_i), .resetn_i(resetn_i), .acc_valid_i(v),
    .acc_write_i(w), .acc_coproc_i(e[17:14]), .acc_opc1_i(e[13:11]),
    .acc_crn_i(e[10:7]), .acc_crm_i(e[6:3]), .acc_opc2_i(e[2:0]),
    .acc_wdata_i(wd), .ext_write_i(ext_w), .ext_wdata_i(ext_d),
    .cur_el_i(el), .cur_sec_i(sec), .el1_a32_i(c[10]), .el2_a32_i(c[9]),
    .el3_a32_i(c[11]), .el2_enabled_i(c[8]), .halted_i(c[7]),
    .user_access_enable_i(c[6]), .trap_general_exceptions_i(c[5]),
    .host_el2_i(c[12]), .fgt_allowed_i(~c[13]),
    .fine_grain_read_trap_i(c[4]),
    .fine_grain_write_trap_i(c[14]), .hyp_pmu_trap_i(c[3]),
    .hyp_pmu_trap_a32_i(c[2]), .monitor_pmu_trap_i(c[1]),
    .secure_debug_disable_i(c[0]), .counter_select_i(cs),
    .acc_done_o(done), .acc_rdata_o(rd), .acc_undef_o(ud),
    .acc_trap_o(tr), .acc_hyp_trap_o(hy), .acc_trap_el_o(tel),
    .acc_syndrome_o(syn), .cycle_count_filter_o(flt),
    .cycle_count_permit_o(pm));
  // ==========================================
  // helpers
  task check(input [31:0] g, input [31:0] x);
    begin
      check_count = check_count + 1;
      if (g !== x) begin
        failures = failures + 1;
        $display("unexpected at %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task acc(input wr, input s, input [31:0] d, input [11:0] ea,
    input [31:0] er);
    begin
      core.access(wr, s, d);
      #1;
      check({20'h0_0000, done, ud, tr, hy, tel, syn}, {20'h0_0000, ea});
      check(rd, er);
    end
  endtask
  task pchk(input [31:0] x, input [1:0] l, input [1:0] s, input p);
    begin
      @(posedge clk_i);
      ext_w <= 1'b1;
      ext_d <= x;
      el <= l;
      sec <= s;
      @(posedge clk_i);
      ext_w <= 1'b0;
      ext_d <= ~x;
      #1;
      check({31'h0, pm}, {31'h0, p});
    end
  endtask
  task tc(input [1:0] l, input [14:0] k, input wr, input [11:0] ea,
    input [31:0] er);
    begin
      @(posedge clk_i);
      el <= l;
      c <= k;
      acc(wr, 1'b0, 32'hffff_ffff, ea, er);
    end
  endtask
  // ==========================================
  // scenarios
  task t_rw;
    begin
      acc(1'b1, 1'b0, 32'hffff_ffff, 12'h800, 32'h0);
      acc(1'b0, 1'b0, 32'h0, 12'h800, 32'hf820_0000);
      acc(1'b1, 1'b1, 32'h4820_0000, 12'h800, 32'h0);
      acc(1'b0, 1'b0, 32'h0, 12'h800, 32'h4820_0000);
      @(posedge clk_i);
      cs <= 5'h00;
      acc(1'b0, 1'b1, 32'h0, 12'h000, 32'h0);
      $display("test rw done");
    end
  endtask
  task t_permit;
    begin
      pchk(32'h0, 2'h0, 2'h0, 1'b1);
      pchk(32'h0, 2'h2, 2'h0, 1'b0);
      pchk(32'h0800_0000, 2'h2, 2'h0, 1'b1);
      pchk(32'h8000_0000, 2'h1, 2'h0, 1'b0);
      pchk(32'h8000_0000, 2'h1, 2'h1, 1'b0);
      pchk(32'ha000_0000, 2'h1, 2'h1, 1'b1);
      pchk(32'h4000_0000, 2'h0, 2'h0, 1'b0);
      pchk(32'h4000_0000, 2'h0, 2'h1, 1'b0);
      pchk(32'h5000_0000, 2'h0, 2'h1, 1'b1);
      pchk(32'h4000_0000, 2'h0, 2'h2, 1'b0);
      pchk(32'h4020_0000, 2'h0, 2'h2, 1'b1);
      pchk(32'h8000_0000, 2'h3, 2'h0, 1'b0);
      pchk(32'h2000_0000, 2'h1, 2'h1, 1'b0);
      $display("test permit done");
    end
  endtask
  task t_trap;
    begin
      tc(2'h0, 15'h0000, 1'b0, 12'ha43, 32'h0);
      tc(2'h0, 15'h0120, 1'b0, 12'ha83, 32'h0);
      tc(2'h0, 15'h0400, 1'b0, 12'hc00, 32'h0);
      tc(2'h0, 15'h0720, 1'b0, 12'h980, 32'h0);
      tc(2'h0, 15'h0150, 1'b0, 12'ha83, 32'h0);
      tc(2'h0, 15'h1170, 1'b0, 12'h800, 32'h2000_0000);
      tc(2'h0, 15'h2150, 1'b0, 12'h800, 32'h2000_0000);
      tc(2'h0, 15'h4140, 1'b1, 12'ha83, 32'h0);
      tc(2'h1, 15'h0148, 1'b1, 12'ha83, 32'h0);
      check(flt, 32'h2000_0000);
      tc(2'h1, 15'h0304, 1'b0, 12'h983, 32'h0);
      tc(2'h1, 15'h0102, 1'b0, 12'hac3, 32'h0);
      tc(2'h1, 15'h0183, 1'b0, 12'hc00, 32'h0);
      tc(2'h1, 15'h0802, 1'b0, 12'h800, 32'h2000_0000);
      tc(2'h2, 15'h0002, 1'b0, 12'hac3, 32'h0);
      $display("test trap done");
    end
  endtask
  // ==========================================
  // verdict
  task print_verdict;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    check(flt & 32'hf800_0000, 32'h0);
    t_rw;
    t_permit;
    t_trap;
    print_verdict;
  end
endmodule // cycle_count_filter_test
